// ==== pkg/iepr_pkg.sv ====
// Behaviour
// - Global gate clear blocks every request
// - Enable bit 6 is a plain software flag
// - Enable bits 5..0 mask six basic sources
// - UART requests on receive or transmit done
// - Timer 2, 1, 0 request from overflow
// - Priority bits 7..6 read 11, ignore writes
// - Priority bits 5..0 select high or low
// - Extended enable 1 masks eight sources
// - One counter-array mask gates all its flags
// - One mask each for SPI and SMBus
// - Extended enable 2 bit 6 reads zero
// - Extended enable 2 masks remaining seven sources
// - High preempts low; lowest index wins ties
// - Requests sampled and decoded every cycle
// - Software-set pending flag requests like hardware
package iepr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses in the special function register space
    localparam logic [7:0] IEPR_ADDR_ENABLE = 8'ha8;
    localparam logic [7:0] IEPR_ADDR_PRIO = 8'hb8;
    localparam logic [7:0] IEPR_ADDR_EXT1 = 8'he6;
    localparam logic [7:0] IEPR_ADDR_EXT2 = 8'he7;

    // Field positions and fixed values
    localparam int IEPR_GATE_BIT = 7;
    localparam int IEPR_SPARE_BIT = 6;
    localparam int IEPR_RESV_BIT = 6;
    localparam logic [1:0] IEPR_PRIO_TOP = 2'h3;
    localparam logic [7:0] IEPR_RESET_VAL = 8'h00;
    localparam logic [7:0] IEPR_EXT2_WMASK = 8'hbf;
    localparam logic [7:0] IEPR_UNMAPPED_VAL = 8'h00;

    // Source slots, in vector (and tie-break) order
    localparam int IEPR_NSRC = 22;
    localparam int IEPR_NBASIC = 6;
    localparam int IEPR_SLOT_UART = 4;
    localparam int IEPR_SLOT_SPI = 6;
    localparam int IEPR_SLOT_SMBUS = 7;
    localparam int IEPR_SLOT_PCA = 9;
    localparam int IEPR_SLOT_UNUSED = 20;
    localparam int IEPR_IDX_W = 5;
    localparam int IEPR_SPI_CAUSES = 4;
    localparam int IEPR_PCA_FLAGS = 6;

    // Processor register access, one request per cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iepr_sfr_req_t;

    // Pending flags from the peripherals, high means pending
    typedef struct packed {
        logic crystal_ok_flag;
        logic [3:0] ext7_4_flag;
        logic adc_done_flag;
        logic timer3_overflow_flag;
        logic cmp1_rise_flag;
        logic cmp1_fall_flag;
        logic cmp0_rise_flag;
        logic cmp0_fall_flag;
        logic [IEPR_PCA_FLAGS-1:0] counter_array_flags;
        logic adc_window_flag;
        logic smbus_irq_flag;
        logic [IEPR_SPI_CAUSES-1:0] spi_flags;
        logic timer2_overflow_flag;
        logic uart_tx_done_flag;
        logic uart_rx_done_flag;
        logic timer1_overflow_flag;
        logic ext_pin1_flag;
        logic timer0_overflow_flag;
        logic ext_pin0_flag;
    } iepr_pend_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] interrupt_enable;
        logic [5:0] source_priority_basic;
        logic [7:0] extended_enable_1;
        logic [7:0] extended_enable_2;
        logic [7:0] rdata;
        logic [IEPR_NSRC-1:0] req;
        logic [IEPR_NSRC-1:0] high;
        logic valid;
        logic [IEPR_IDX_W-1:0] index;
        logic is_high;
    } iepr_state_t;

endpackage : iepr_pkg

// ==== rtl/iepr_top.sv ====
module iepr_top
    import iepr_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    // Register access from the processor core
    input wire iepr_sfr_req_t SFR_REQ_I,
    output logic [7:0] SFR_RDATA_O,
    // Peripheral pending flags
    input wire iepr_pend_t PEND_I,
    // Service state of the core
    input wire logic IN_SERVICE_LOW_I,
    input wire logic IN_SERVICE_HIGH_I,
    // Requests toward the core
    output logic [IEPR_NSRC-1:0] IRQ_REQ_O,
    output logic [IEPR_NSRC-1:0] IRQ_HIGH_O,
    output logic IRQ_VALID_O,
    output logic [IEPR_IDX_W-1:0] IRQ_INDEX_O,
    output logic IRQ_IS_HIGH_O
);

    ////////////////////////////////////////////////////////////////////////
    // Lowest set index of a vector; bit IEPR_IDX_W is the found flag
    function automatic logic [IEPR_IDX_W:0] first_set(input logic [IEPR_NSRC-1:0] v);
        logic [IEPR_IDX_W:0] res;
        res = '0;
        for (int i = IEPR_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                res = {1'b1, IEPR_IDX_W'(i)};
            end
        end
        return res;
    endfunction : first_set

    ////////////////////////////////////////////////////////////////////////
    iepr_state_t r;
    iepr_state_t next_r;
    logic [IEPR_NSRC-1:0] pend_v;
    logic [IEPR_NSRC-1:0] mask_v;
    logic [IEPR_NSRC-1:0] prio_v;
    logic [IEPR_NSRC-1:0] next_req;
    logic [IEPR_NSRC-1:0] next_high;
    logic [IEPR_IDX_W:0] pick_high;
    logic [IEPR_IDX_W:0] pick_low;
    logic gate;

    // Pending vector; grouped causes fold into one slot each
    always_comb begin
        pend_v = '0;
        pend_v[0] = PEND_I.ext_pin0_flag;
        pend_v[1] = PEND_I.timer0_overflow_flag;
        pend_v[2] = PEND_I.ext_pin1_flag;
        pend_v[3] = PEND_I.timer1_overflow_flag;
        pend_v[IEPR_SLOT_UART] = PEND_I.uart_rx_done_flag | PEND_I.uart_tx_done_flag;
        pend_v[5] = PEND_I.timer2_overflow_flag;
        pend_v[IEPR_SLOT_SPI] = |PEND_I.spi_flags;
        pend_v[IEPR_SLOT_SMBUS] = PEND_I.smbus_irq_flag;
        pend_v[8] = PEND_I.adc_window_flag;
        pend_v[IEPR_SLOT_PCA] = |PEND_I.counter_array_flags;
        pend_v[10] = PEND_I.cmp0_fall_flag;
        pend_v[11] = PEND_I.cmp0_rise_flag;
        pend_v[12] = PEND_I.cmp1_fall_flag;
        pend_v[13] = PEND_I.cmp1_rise_flag;
        pend_v[14] = PEND_I.timer3_overflow_flag;
        pend_v[15] = PEND_I.adc_done_flag;
        pend_v[19:16] = PEND_I.ext7_4_flag;
        pend_v[IEPR_SLOT_UNUSED] = 1'b0;
        pend_v[21] = PEND_I.crystal_ok_flag;
    end

    // Mask bits line up with the slots; bit 6 of enable is left out
    assign mask_v = {r.extended_enable_2, r.extended_enable_1,
                     r.interrupt_enable[IEPR_NBASIC-1:0]};
    // Extended priorities live elsewhere, so those slots stay low
    assign prio_v = {{(IEPR_NSRC-IEPR_NBASIC){1'b0}}, r.source_priority_basic};
    assign gate = r.interrupt_enable[IEPR_GATE_BIT];
    // A flag set by software looks the same here as one set by hardware
    assign next_req = pend_v & mask_v & {IEPR_NSRC{gate}};
    assign next_high = prio_v;
    assign pick_high = first_set(next_req & next_high);
    assign pick_low = first_set(next_req & ~next_high);

    ////////////////////////////////////////////////////////////////////////
    // Register writes, reads and the per-cycle decode
    always_comb begin
        next_r = r;
        if (SFR_REQ_I.wr) begin
            case (SFR_REQ_I.addr)
                IEPR_ADDR_ENABLE: begin
                    next_r.interrupt_enable = SFR_REQ_I.wdata;
                end
                IEPR_ADDR_PRIO: begin
                    next_r.source_priority_basic = SFR_REQ_I.wdata[5:0];
                end
                IEPR_ADDR_EXT1: begin
                    next_r.extended_enable_1 = SFR_REQ_I.wdata;
                end
                IEPR_ADDR_EXT2: begin
                    next_r.extended_enable_2 = SFR_REQ_I.wdata & IEPR_EXT2_WMASK;
                end
                default: begin
                    next_r.interrupt_enable = r.interrupt_enable;
                end
            endcase
        end
        // Read data shows the value held before a same-cycle write
        if (SFR_REQ_I.rd) begin
            case (SFR_REQ_I.addr)
                IEPR_ADDR_ENABLE: begin
                    next_r.rdata = r.interrupt_enable;
                end
                IEPR_ADDR_PRIO: begin
                    next_r.rdata = {IEPR_PRIO_TOP, r.source_priority_basic};
                end
                IEPR_ADDR_EXT1: begin
                    next_r.rdata = r.extended_enable_1;
                end
                IEPR_ADDR_EXT2: begin
                    next_r.rdata = r.extended_enable_2;
                end
                default: begin
                    next_r.rdata = IEPR_UNMAPPED_VAL;
                end
            endcase
        end
        // Sampled and decoded on every edge, no hold-off
        next_r.req = next_req;
        next_r.high = next_high;
        // High beats low; nothing may interrupt a high routine
        if (pick_high[IEPR_IDX_W] && !IN_SERVICE_HIGH_I) begin
            next_r.valid = 1'b1;
            next_r.index = pick_high[IEPR_IDX_W-1:0];
            next_r.is_high = 1'b1;
        end else if (pick_low[IEPR_IDX_W] && !IN_SERVICE_HIGH_I && !IN_SERVICE_LOW_I) begin
            next_r.valid = 1'b1;
            next_r.index = pick_low[IEPR_IDX_W-1:0];
            next_r.is_high = 1'b0;
        end else begin
            next_r.valid = 1'b0;
            next_r.index = '0;
            next_r.is_high = 1'b0;
        end
    end

    // State register; everything starts masked and low
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state
    assign SFR_RDATA_O = r.rdata;
    assign IRQ_REQ_O = r.req;
    assign IRQ_HIGH_O = r.high;
    assign IRQ_VALID_O = r.valid;
    assign IRQ_INDEX_O = r.index;
    assign IRQ_IS_HIGH_O = r.is_high;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SRST_I);

    sequence s_wr(logic [7:0] a);
        SFR_REQ_I.wr && !SFR_REQ_I.rd && SFR_REQ_I.addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        SFR_REQ_I.rd && !SFR_REQ_I.wr && SFR_REQ_I.addr == a;
    endsequence

    a_gate_blocks_all: assert property (
        !gate |=> IRQ_REQ_O == '0)
        else $error("request seen with global gate clear");

    // The bench idles one cycle between accesses, so allow one quiet cycle between write and read
    a_spare_flag_rw: assert property (
        s_wr(IEPR_ADDR_ENABLE) ##1 !SFR_REQ_I.wr ##1 s_rd(IEPR_ADDR_ENABLE)
        |=> SFR_RDATA_O == $past(SFR_REQ_I.wdata, 3))
        else $error("enable register readback wrong");

    a_req_formula: assert property (
        1'b1 |=> IRQ_REQ_O == $past(pend_v & mask_v & {IEPR_NSRC{gate}}))
        else $error("request not pending and mask and gate");

    a_uart_either: assert property (
        gate && r.interrupt_enable[IEPR_SLOT_UART]
        && (PEND_I.uart_rx_done_flag || PEND_I.uart_tx_done_flag)
        |=> IRQ_REQ_O[IEPR_SLOT_UART])
        else $error("uart request missing");

    a_pca_combined: assert property (
        gate && r.extended_enable_1[3] && |PEND_I.counter_array_flags
        |=> IRQ_REQ_O[IEPR_SLOT_PCA])
        else $error("counter array request missing");

    a_spi_combined: assert property (
        gate && r.extended_enable_1[0] && |PEND_I.spi_flags |=> IRQ_REQ_O[IEPR_SLOT_SPI])
        else $error("spi request missing");

    a_prio_top_ones: assert property (
        s_rd(IEPR_ADDR_PRIO) |=> SFR_RDATA_O[7:6] == IEPR_PRIO_TOP)
        else $error("priority top bits not 11");

    a_resv_reads_zero: assert property (
        s_rd(IEPR_ADDR_EXT2) |=> !SFR_RDATA_O[IEPR_RESV_BIT])
        else $error("reserved bit read as one");

    a_prio_write_used: assert property (
        s_wr(IEPR_ADDR_PRIO) |-> ##2 IRQ_HIGH_O[5:0] == $past(SFR_REQ_I.wdata[5:0], 2))
        else $error("priority write not applied");

    a_no_preempt_high: assert property (
        IN_SERVICE_HIGH_I |=> !IRQ_VALID_O)
        else $error("high routine was preempted");

    a_winner_lowest: assert property (
        IRQ_VALID_O |-> IRQ_REQ_O[IRQ_INDEX_O] && IRQ_HIGH_O[IRQ_INDEX_O] == IRQ_IS_HIGH_O
        && ((IRQ_REQ_O & (IRQ_IS_HIGH_O ? IRQ_HIGH_O : ~IRQ_HIGH_O))
            & ((IEPR_NSRC'(1) << IRQ_INDEX_O) - IEPR_NSRC'(1))) == '0)
        else $error("winner is not lowest index at its level");

    a_reset_clear: assert property (disable iff (1'b0)
        SRST_I |=> r.interrupt_enable == IEPR_RESET_VAL && r.extended_enable_1 == IEPR_RESET_VAL
        && r.extended_enable_2 == IEPR_RESET_VAL && r.source_priority_basic == '0)
        else $error("registers not cleared by reset");

endmodule : iepr_top

// ==== verif/iepr_src_model.sv ====
module iepr_src_model
    import iepr_pkg::*;
(
    // Peripheral events and service state from the bench
    input wire iepr_pend_t event_i,
    input wire logic [1:0] service_i,
    // Toward the block
    output iepr_pend_t pend_o,
    output logic in_service_low_o,
    output logic in_service_high_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Flags are plain levels, so a software-set flag looks like a hardware event
    assign pend_o = event_i;
    // Core service level: bit 0 low routine, bit 1 high routine
    assign in_service_low_o = service_i[0];
    assign in_service_high_o = service_i[1];
endmodule : iepr_src_model

// ==== verif/testbench.sv ====
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end

module testbench;
    import iepr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic srst;
    iepr_sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    iepr_pend_t ev;
    iepr_pend_t pend;
    logic [1:0] svc;
    logic svc_low;
    logic svc_high;
    logic [IEPR_NSRC-1:0] irq_req;
    logic [IEPR_NSRC-1:0] irq_high;
    logic irq_valid;
    logic [IEPR_IDX_W-1:0] irq_index;
    logic irq_is_high;
    int fails = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////////////
    // Design and far side
    iepr_top dut (.CLOCK_I(clk), .SRST_I(srst), .SFR_REQ_I(sfr_req), .SFR_RDATA_O(sfr_rdata),
        .PEND_I(pend), .IN_SERVICE_LOW_I(svc_low), .IN_SERVICE_HIGH_I(svc_high),
        .IRQ_REQ_O(irq_req), .IRQ_HIGH_O(irq_high), .IRQ_VALID_O(irq_valid),
        .IRQ_INDEX_O(irq_index), .IRQ_IS_HIGH_O(irq_is_high));
    iepr_src_model partner (.event_i(ev), .service_i(svc), .pend_o(pend),
        .in_service_low_o(svc_low), .in_service_high_o(svc_high));

    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive 1 ns after the edge, so outputs of that edge have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // One access, then an idle cycle so no strobe is set twice in one step
    task automatic access(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
        sfr_req = '{rd: r, wr: w, addr: a, wdata: d};
        tick(1);
        sfr_req = '{rd: 1'b0, wr: 1'b0, addr: a, wdata: d};
        tick(1);
    endtask : access

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        access(1'b0, 1'b1, a, d);
    endtask : sfr_write

    // Read data holds until the next read, so it is still valid after the idle cycle
    task automatic sfr_check(input logic [7:0] a, input logic [7:0] e);
        access(1'b1, 1'b0, a, 8'h00);
        `CHK("read data", e, sfr_rdata)
    endtask : sfr_check

    // Masks by slot; spare and reserved bits always written 0
    task automatic set_masks(input logic [21:0] m, input logic g);
        sfr_write(IEPR_ADDR_ENABLE, {g, 1'b0, m[5:0]});
        sfr_write(IEPR_ADDR_EXT1, m[13:6]);
        sfr_write(IEPR_ADDR_EXT2, {m[21], 1'b0, m[19:14]});
    endtask : set_masks

    // Slot that each pending-flag bit belongs to
    function automatic int slot_of(input int b);
        if (b < 4) return b;
        if (b < 6) return 4;
        if (b == 6) return 5;
        if (b < 11) return 6;
        if (b == 11) return 7;
        if (b == 12) return 8;
        if (b < 19) return 9;
        if (b < 29) return b - 9;
        return 21;
    endfunction : slot_of

    task automatic complete_run();
        $display("Checks %0d, errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Cut a hang short
    initial begin
        #100000;
        fails++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [21:0] one;
        int s;
        srst = 1'b1;
        sfr_req = '0;
        ev = '0;
        svc = 2'b00;
        tick(2);
        srst = 1'b0;
        sfr_check(IEPR_ADDR_ENABLE, 8'h00);
        sfr_check(IEPR_ADDR_PRIO, 8'hc0);
        sfr_check(IEPR_ADDR_EXT1, 8'h00);
        sfr_check(IEPR_ADDR_EXT2, 8'h00);
        ev = '1;
        sfr_write(IEPR_ADDR_ENABLE, 8'h7f);
        `CHK("ungated", 22'h0, irq_req)
        sfr_check(IEPR_ADDR_ENABLE, 8'h7f);
        sfr_write(IEPR_ADDR_PRIO, 8'h3f);
        sfr_check(IEPR_ADDR_PRIO, 8'hff);
        sfr_write(IEPR_ADDR_EXT1, 8'hff);
        sfr_check(IEPR_ADDR_EXT1, 8'hff);
        sfr_write(IEPR_ADDR_EXT2, 8'hff);
        sfr_check(IEPR_ADDR_EXT2, 8'hbf);
        sfr_check(8'h55, 8'h00);
        sfr_write(IEPR_ADDR_ENABLE, 8'hbf);
        // One high source at a time must beat all lower-index low ones
        for (int p = 0; p < 6; p++) begin
            sfr_write(IEPR_ADDR_PRIO, 8'h01 << p);
            `CHK("high", 22'h1 << p, irq_high)
            `CHK("winner", 5'(p), irq_index)
            `CHK("is high", 1'b1, irq_is_high)
            svc = 2'b01;
            tick(1);
            `CHK("preempt", 1'b1, irq_valid)
            svc = 2'b10;
            tick(1);
            `CHK("no preempt", 1'b0, irq_valid)
            svc = 2'b00;
        end
        sfr_write(IEPR_ADDR_PRIO, 8'h00);
        `CHK("tie", 5'd0, irq_index)
        `CHK("low winner", 1'b0, irq_is_high)
        svc = 2'b01;
        tick(1);
        `CHK("low blocked", 1'b0, irq_valid)
        svc = 2'b00;
        // Every flag bit reaches its own slot, masked by its bit and the gate
        for (int b = 0; b < 30; b++) begin
            s = slot_of(b);
            one = 22'h1 << s;
            set_masks(22'h3fffff, 1'b1);
            ev = iepr_pend_t'(30'h1 << b);
            tick(1);
            `CHK("request", one, irq_req)
            `CHK("index", 5'(s), irq_index)
            set_masks(~one, 1'b1);
            `CHK("masked", 22'h0, irq_req)
            set_masks(22'h3fffff, 1'b0);
            `CHK("gated", 22'h0, irq_req)
            `CHK("valid", 1'b0, irq_valid)
        end
        // Reset in mid-run with a request live and priorities set
        sfr_write(IEPR_ADDR_PRIO, 8'h3f);
        sfr_write(IEPR_ADDR_ENABLE, 8'hff);
        `CHK("live", 22'h200000, irq_req)
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        `CHK("reset req", 22'h0, irq_req)
        `CHK("reset valid", 1'b0, irq_valid)
        sfr_check(IEPR_ADDR_ENABLE, 8'h00);
        sfr_check(IEPR_ADDR_PRIO, 8'hc0);
        sfr_check(IEPR_ADDR_EXT1, 8'h00);
        sfr_check(IEPR_ADDR_EXT2, 8'h00);
        complete_run();
    end
endmodule : testbench
